// file: hdl/lifephase_cfg.svh
// Constants for the configuration lifephase sequencer and pin multiplexer
// Overview of operation
// - In mode sampling the device drives its configuration pins and samples the three mode pins.
// - Mode 0 is master serial, 1 and 7 slave serial, 2 and 6 slave parallel.
// - A slave mode leads from mode sampling into idle, where nothing is configured.
// - Idle releases init, serial data and both status pins to general use; every other dual pin is free too.
// - Master serial goes from mode sampling straight into download, skipping idle.
// - From idle, download starts only on a start trigger from the external master.
// - Download runs in one of five contexts chosen by the captured mode; master serial and mode 7 slave serial use the same pins.
// - Download entered from idle leaves general pins as inputs with pull-up.
// - Download entered from run leaves general pins as the loaded design set them.
// - The select/address pin is chip select input in mode 2 and address output in mode 6.
// - Cascade, check and tri-state pins take their role only when the bitstream enables it.
// - In slave parallel modes data bits 1 to 7 always carry configuration during download.
// - Data bits 8 to 15 carry configuration only with 16-bit access selected.
// - In run the loaded design takes over all general pins.
`ifndef LIFEPHASE_CFG_SVH
`define LIFEPHASE_CFG_SVH

// =====================================================================
// Mode encodings on the three mode pins
`define MODE_MASTER_SERIAL  3'h0
`define MODE_SLAVE_SER_CS   3'h1
`define MODE_SLAVE_SER      3'h7
`define MODE_SLAVE_PAR_CS   3'h2
`define MODE_SLAVE_PAR_ADDR 3'h6

// =====================================================================
// Reset values and timing
`define MODE_RST            3'h0
`define SAMPLE_NS           8
`define SAMPLE_CYC          ((`SAMPLE_NS + 3) / 4)

`endif

// file: hdl/lifephase_pkg.sv
// Types for the configuration lifephase sequencer and pin multiplexer
package lifephase_pkg;

  typedef enum logic [2:0] {
    PH_SAMPLE,
    PH_IDLE,
    PH_DOWNLOAD,
    PH_RUN
  } phase_e;

  typedef enum logic [2:0] {
    CTX_MASTER_SERIAL,
    CTX_SLAVE_SER_CS,
    CTX_SLAVE_SER,
    CTX_SLAVE_PAR_CS,
    CTX_SLAVE_PAR_ADDR,
    CTX_INVALID
  } ctx_e;

  // Per-pin role: 1 means configuration function
  typedef struct packed {
    logic init_status;
    logic serial_data;
    logic cfg_status_low;
    logic cfg_status_high;
    logic slave_select;
    logic sel_as_chip_select;
    logic sel_as_address;
    logic cascade_select;
    logic check_flag;
    logic output_tristate;
    logic [6:0] data_low;
    logic [7:0] data_high;
  } pin_role_s;

  // General-purpose pin policy
  typedef struct packed {
    logic pullup_inputs;
    logic design_owned;
  } gpio_policy_s;

  // Bitstream options supplied by the download engine
  typedef struct packed {
    logic cascade_en;
    logic check_en;
    logic tristate_en;
    logic wide16_en;
  } bs_opt_s;

endpackage

// file: hdl/mode_decode.sv
// Decoder from the captured mode value to a download context
`timescale 1ns/1ps
module mode_decode (
  // Captured mode
  input  wire logic [2:0]          mode,
  // Decoded context
  output lifephase_pkg::ctx_e      ctx,
  output logic                     is_master
);
  `include "lifephase_cfg.svh"

  always_comb begin
    is_master = 1'b0;
    case (mode)
      `MODE_MASTER_SERIAL: begin
        ctx       = lifephase_pkg::CTX_MASTER_SERIAL;
        is_master = 1'b1;
      end
      `MODE_SLAVE_SER_CS:   ctx = lifephase_pkg::CTX_SLAVE_SER_CS;
      `MODE_SLAVE_SER:      ctx = lifephase_pkg::CTX_SLAVE_SER;
      `MODE_SLAVE_PAR_CS:   ctx = lifephase_pkg::CTX_SLAVE_PAR_CS;
      `MODE_SLAVE_PAR_ADDR: ctx = lifephase_pkg::CTX_SLAVE_PAR_ADDR;
      default:              ctx = lifephase_pkg::CTX_INVALID;
    endcase
  end
endmodule

// file: hdl/config_lifephase_pin_mux.sv
// Lifephase sequencer and dual-function pin assignment of the configuration port
`timescale 1ns/1ps
module config_lifephase_pin_mux (
  // Clock and reset
  input  wire logic                        clk_sys,
  input  wire logic                        nrst,
  // Configuration pins sampled from outside
  input  wire logic [2:0]                  mode_select_pins,
  input  wire logic                        start_trigger,
  // Download engine handshake
  input  wire logic                        download_done,
  input  wire logic                        reconfig_req,
  input  wire lifephase_pkg::bs_opt_s      bs_opt,
  // Phase and context
  output lifephase_pkg::phase_e            phase,
  output lifephase_pkg::ctx_e              dl_context,
  output logic [2:0]                       mode_captured,
  output logic                             cfg_if_driven,
  output logic                             design_running,
  // Pin roles
  output lifephase_pkg::pin_role_s         pin_role,
  output lifephase_pkg::gpio_policy_s      gpio_policy
);
  `include "lifephase_cfg.svh"

  // =====================================================================
  // State
  typedef struct packed {
    logic [2:0]                  mode_s1;
    logic [2:0]                  mode_s2;
    logic                        trig_s1;
    logic                        trig_s2;
    logic [1:0]                  sample_cnt;
    logic                        from_run;
    lifephase_pkg::phase_e       phase;
    logic [2:0]                  mode;
    lifephase_pkg::ctx_e         ctx;
    logic                        drive;
    logic                        run;
    lifephase_pkg::pin_role_s    role;
    lifephase_pkg::gpio_policy_s pol;
  } state_s;

  state_s state_r;
  state_s state_nxt;

  lifephase_pkg::ctx_e dec_ctx;
  logic                dec_master;

  // Decode from the synchronised pins; latched once at end of sampling
  mode_decode mode_decode_inst (
    .mode      (state_r.mode_s2),
    .ctx       (dec_ctx),
    .is_master (dec_master)
  );

  // =====================================================================
  // Pin role for one phase and context
  function automatic lifephase_pkg::pin_role_s roles(
    input lifephase_pkg::phase_e ph,
    input lifephase_pkg::ctx_e   cx,
    input lifephase_pkg::bs_opt_s op
  );
    lifephase_pkg::pin_role_s r;
    logic par;
    r   = '0;
    par = (cx == lifephase_pkg::CTX_SLAVE_PAR_CS) || (cx == lifephase_pkg::CTX_SLAVE_PAR_ADDR);
    case (ph)
      lifephase_pkg::PH_SAMPLE: begin
        // Status and serial pins drive while the mode pins are read
        r.init_status     = 1'b1;
        r.serial_data     = 1'b1;
        r.cfg_status_low  = 1'b1;
        r.cfg_status_high = 1'b1;
      end
      lifephase_pkg::PH_IDLE: begin
        // Interface released: a slave waits with every dual pin free
        r.init_status     = 1'b0;
        r.serial_data     = 1'b0;
        r.cfg_status_low  = 1'b0;
        r.cfg_status_high = 1'b0;
        r.data_low        = 7'h00;
        r.data_high       = 8'h00;
      end
      lifephase_pkg::PH_DOWNLOAD: begin
        r.init_status        = 1'b1;
        r.serial_data        = 1'b1;
        r.cfg_status_low     = 1'b1;
        r.cfg_status_high    = 1'b1;
        r.slave_select       = (cx == lifephase_pkg::CTX_SLAVE_SER_CS);
        r.sel_as_chip_select = (cx == lifephase_pkg::CTX_SLAVE_PAR_CS);
        r.sel_as_address     = (cx == lifephase_pkg::CTX_SLAVE_PAR_ADDR);
        r.cascade_select     = op.cascade_en;
        r.check_flag         = op.check_en;
        r.output_tristate    = op.tristate_en;
        // Serial contexts keep the data pins general
        r.data_low           = {7{par}};
        r.data_high          = {8{par & op.wide16_en}};
      end
      lifephase_pkg::PH_RUN: begin
        // The loaded design owns every dual pin from here on
        r.init_status     = 1'b0;
        r.serial_data     = 1'b0;
        r.cfg_status_low  = 1'b0;
        r.cfg_status_high = 1'b0;
        r.data_low        = 7'h00;
        r.data_high       = 8'h00;
      end
      default: begin
        r = '0;
      end
    endcase
    return r;
  endfunction

  // =====================================================================
  // General-purpose pin policy for one phase
  function automatic lifephase_pkg::gpio_policy_s policy(
    input lifephase_pkg::phase_e ph,
    input logic                  loaded
  );
    lifephase_pkg::gpio_policy_s p;
    p = '0;
    case (ph)
      lifephase_pkg::PH_RUN: begin
        p.design_owned = 1'b1;
      end
      lifephase_pkg::PH_DOWNLOAD: begin
        // A partial reload must not disturb the pins the running design set
        p.design_owned = loaded;
      end
      default: begin
        p.design_owned = 1'b0;
      end
    endcase
    // With nothing loaded yet, free pins sit as inputs with pull-up
    p.pullup_inputs = !p.design_owned;
    return p;
  endfunction

  // =====================================================================
  // Next state
  always_comb begin
    state_nxt         = state_r;
    state_nxt.mode_s1 = mode_select_pins;
    state_nxt.mode_s2 = state_r.mode_s1;
    state_nxt.trig_s1 = start_trigger;
    state_nxt.trig_s2 = state_r.trig_s1;
    case (state_r.phase)
      lifephase_pkg::PH_SAMPLE: begin
        state_nxt.drive = 1'b1;
        // Wait for the pins to pass the synchroniser before trusting them
        if (state_r.sample_cnt != 2'(`SAMPLE_CYC + 1)) begin
          state_nxt.sample_cnt = state_r.sample_cnt + 2'h1;
        end else begin
          state_nxt.mode = state_r.mode_s2;
          state_nxt.ctx  = dec_ctx;
          if (dec_master) begin
            state_nxt.phase = lifephase_pkg::PH_DOWNLOAD;
          end else begin
            state_nxt.phase = lifephase_pkg::PH_IDLE;
            state_nxt.drive = 1'b0;
          end
          state_nxt.from_run = 1'b0;
        end
      end
      lifephase_pkg::PH_IDLE: begin
        // An unknown mode stays idle: no context to download into
        // The trigger passes two flops, so one clock of it is enough; it is acted on three edges after reaching the pin
        if (state_r.trig_s2 && state_r.ctx != lifephase_pkg::CTX_INVALID) begin
          state_nxt.phase    = lifephase_pkg::PH_DOWNLOAD;
          state_nxt.from_run = 1'b0;
          state_nxt.drive    = 1'b1;
        end
      end
      lifephase_pkg::PH_DOWNLOAD: begin
        // The engine reports the end; the bitstream itself is not seen here
        if (download_done) begin
          state_nxt.phase = lifephase_pkg::PH_RUN;
          state_nxt.drive = 1'b0;
        end
      end
      lifephase_pkg::PH_RUN: begin
        // Partial reload: the design keeps its pins while new frames arrive
        if (reconfig_req) begin
          state_nxt.phase    = lifephase_pkg::PH_DOWNLOAD;
          state_nxt.from_run = 1'b1;
          state_nxt.drive    = 1'b1;
        end
      end
      default: begin
        // A corrupted phase restarts from mode sampling
        state_nxt.phase = lifephase_pkg::PH_SAMPLE;
      end
    endcase
    state_nxt.run  = (state_nxt.phase == lifephase_pkg::PH_RUN);
    state_nxt.role = roles(state_nxt.phase, state_nxt.ctx, bs_opt);
    state_nxt.pol  = policy(state_nxt.phase, state_nxt.from_run);
  end

  // =====================================================================
  // Registers
  // Reset lands in mode sampling with the interface already driven
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_r                   <= '0;
      state_r.phase             <= lifephase_pkg::PH_SAMPLE;
      state_r.mode              <= `MODE_RST;
      state_r.ctx               <= lifephase_pkg::CTX_MASTER_SERIAL;
      state_r.drive             <= 1'b1;
      state_r.role.init_status  <= 1'b1;
      state_r.role.serial_data  <= 1'b1;
      state_r.role.cfg_status_low  <= 1'b1;
      state_r.role.cfg_status_high <= 1'b1;
      state_r.pol.pullup_inputs <= 1'b1;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign phase          = state_r.phase;
  assign dl_context     = state_r.ctx;
  assign mode_captured  = state_r.mode;
  assign cfg_if_driven  = state_r.drive;
  assign design_running = state_r.run;
  assign pin_role       = state_r.role;
  assign gpio_policy    = state_r.pol;

endmodule

// file: testbench/config_lifephase_pin_mux_monitor.sv
// Assertion checker bound to the lifephase sequencer and pin multiplexer
`timescale 1ns/1ps
module config_lifephase_pin_mux_monitor (
  // Clock and reset
  input wire logic                        clk_sys,
  input wire logic                        nrst,
  // Inputs
  input wire logic                        start_trigger,
  input wire lifephase_pkg::bs_opt_s      bs_opt,
  // Outputs
  input wire lifephase_pkg::phase_e       phase,
  input wire logic [2:0]                  mode_captured,
  input wire logic                        cfg_if_driven,
  input wire logic                        design_running,
  input wire lifephase_pkg::pin_role_s    pin_role,
  input wire lifephase_pkg::gpio_policy_s gpio_policy
);
  // ====
  // Helpers
  wire s_smp = phase == lifephase_pkg::PH_SAMPLE;
  wire s_idl = phase == lifephase_pkg::PH_IDLE;
  wire s_dl  = phase == lifephase_pkg::PH_DOWNLOAD;
  wire s_run = phase == lifephase_pkg::PH_RUN;
  // Roles lag their inputs by one edge, so options are compared one cycle late
  lifephase_pkg::bs_opt_s opt_q;
  always_ff @(posedge clk_sys) opt_q <= bs_opt;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // ====
  // Properties
  property p_leave; $past(s_smp) && !s_smp |-> (mode_captured == 3'h0 ? s_dl : s_idl); endproperty
  a_leave: assert property (p_leave) else $error("wrong phase after sampling");
  property p_idle; $past(s_idl) && s_idl |-> !cfg_if_driven && !(pin_role.init_status
    || pin_role.serial_data || pin_role.cfg_status_low || pin_role.cfg_status_high); endproperty
  a_idle: assert property (p_idle) else $error("idle keeps interface");
  // Trigger pin, two synchroniser flops, then the phase register: three edges
  property p_start; $past(s_idl) && s_dl |-> $past(start_trigger, 3); endproperty
  a_start: assert property (p_start) else $error("download without trigger");
  property p_sel; $past(s_dl) && s_dl |-> pin_role.sel_as_chip_select == (mode_captured == 3'h2)
    && pin_role.sel_as_address == (mode_captured == 3'h6); endproperty
  a_sel: assert property (p_sel) else $error("select pin role wrong");
  property p_data; $past(s_dl) && s_dl && mode_captured[1:0] == 2'h2 |->
    pin_role.data_low == 7'h7f && pin_role.data_high == {8{opt_q.wide16_en}}; endproperty
  a_data: assert property (p_data) else $error("data pin roles wrong");
  property p_opt; $past(s_dl) && s_dl |-> {pin_role.cascade_select, pin_role.check_flag,
    pin_role.output_tristate} == {opt_q.cascade_en, opt_q.check_en, opt_q.tristate_en}; endproperty
  a_opt: assert property (p_opt) else $error("option pin roles wrong");
  property p_hold; !s_smp |=> $stable(mode_captured); endproperty
  a_hold: assert property (p_hold) else $error("captured mode changed");
  property p_run; $past(s_run) && s_run |-> design_running && gpio_policy.design_owned
    && !gpio_policy.pullup_inputs; endproperty
  a_run: assert property (p_run) else $error("run does not hand over");
  property p_drive; cfg_if_driven == (s_smp || s_dl) && (!s_smp || (pin_role.init_status
    && pin_role.serial_data && pin_role.cfg_status_low && pin_role.cfg_status_high)); endproperty
  a_drive: assert property (p_drive) else $error("interface drive wrong for phase");
  c_master: cover property (s_smp ##1 s_dl);
  c_slave: cover property (s_idl ##1 s_dl);
  c_reload: cover property (s_run ##1 s_dl);
endmodule

bind config_lifephase_pin_mux config_lifephase_pin_mux_monitor config_lifephase_pin_mux_monitor_inst (
  .clk_sys(clk_sys), .nrst(nrst), .start_trigger(start_trigger), .bs_opt(bs_opt),
  .phase(phase), .mode_captured(mode_captured), .cfg_if_driven(cfg_if_driven),
  .design_running(design_running), .pin_role(pin_role), .gpio_policy(gpio_policy));

// file: testbench/cfg_master_model.sv
// Behavioural external configuration master driving mode pins and start trigger
`timescale 1ns/1ps
module cfg_master_model (
  // Clock
  input  wire logic       clk_sys,
  // Requests from the bench
  input  wire logic [2:0] mode_set,
  input  wire logic       go,
  // Pins toward the device
  output logic [2:0]      mode_select_pins,
  output logic            start_trigger
);
  // Pins launch just after an edge like a board master, never mid-cycle
  initial {mode_select_pins, start_trigger} = 4'h0;
  always @(posedge clk_sys) begin
    mode_select_pins <= mode_set;
    start_trigger    <= go;
  end
endmodule

// file: testbench/config_lifephase_pin_mux_tb.sv
// Self-checking bench for the lifephase sequencer and pin multiplexer
`timescale 1ns/1ps
module config_lifephase_pin_mux_tb;
  // ====
  // Signals
  logic                        clk_sys, nrst, go, download_done, reconfig_req;
  logic                        start_trigger, cfg_if_driven, design_running;
  logic [2:0]                  mode_set, mode_select_pins, mode_captured;
  lifephase_pkg::bs_opt_s      bs_opt;
  lifephase_pkg::phase_e       phase;
  lifephase_pkg::ctx_e         ctx_seen;
  lifephase_pkg::pin_role_s    pin_role;
  lifephase_pkg::gpio_policy_s gpio_policy;
  int                          n_errors, compares, cyc;
  config_lifephase_pin_mux config_lifephase_pin_mux_inst (.clk_sys(clk_sys), .nrst(nrst),
    .mode_select_pins(mode_select_pins), .start_trigger(start_trigger),
    .download_done(download_done), .reconfig_req(reconfig_req), .bs_opt(bs_opt),
    .phase(phase), .dl_context(ctx_seen), .mode_captured(mode_captured),
    .cfg_if_driven(cfg_if_driven), .design_running(design_running),
    .pin_role(pin_role), .gpio_policy(gpio_policy));
  cfg_master_model cfg_master_model_inst (.clk_sys(clk_sys), .mode_set(mode_set), .go(go),
    .mode_select_pins(mode_select_pins), .start_trigger(start_trigger));
  // ====
  // Expectations
  function automatic lifephase_pkg::ctx_e exp_ctx(logic [2:0] m);
    case (m)
      3'h0: return lifephase_pkg::CTX_MASTER_SERIAL;
      3'h1: return lifephase_pkg::CTX_SLAVE_SER_CS;
      3'h7: return lifephase_pkg::CTX_SLAVE_SER;
      3'h2: return lifephase_pkg::CTX_SLAVE_PAR_CS;
      3'h6: return lifephase_pkg::CTX_SLAVE_PAR_ADDR;
      default: return lifephase_pkg::CTX_INVALID;
    endcase
  endfunction
  function automatic lifephase_pkg::pin_role_s exp_role(logic [2:0] m, lifephase_pkg::bs_opt_s o);
    lifephase_pkg::pin_role_s r;
    r = '0;
    {r.init_status, r.serial_data, r.cfg_status_low, r.cfg_status_high} = 4'hf;
    r.slave_select = m == 3'h1;
    r.sel_as_chip_select = m == 3'h2;
    r.sel_as_address = m == 3'h6;
    {r.cascade_select, r.check_flag, r.output_tristate} = {o.cascade_en, o.check_en, o.tristate_en};
    if (m[1:0] == 2'h2) begin
      r.data_low = 7'h7f;
      r.data_high = {8{o.wide16_en}};
    end
    return r;
  endfunction
  // ====
  // Tasks
  task automatic tick(int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic summarize();
    if (n_errors == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic dl_check(logic [2:0] m, logic [1:0] pol);
    chk("download", phase, lifephase_pkg::PH_DOWNLOAD);
    chk("roles", pin_role, exp_role(m, bs_opt));
    chk("policy", gpio_policy, pol);
  endtask
  task automatic run_mode(logic [2:0] m, lifephase_pkg::bs_opt_s o);
    logic v;
    v = m inside {3'h0, 3'h1, 3'h2, 3'h6, 3'h7};
    nrst = 1'b0;
    mode_set = m;
    bs_opt = o;
    tick(4);
    chk("reset", {phase, cfg_if_driven, gpio_policy, pin_role},
      {lifephase_pkg::PH_SAMPLE, 1'b1, 2'h2, 4'hf, 21'h0});
    nrst = 1'b1;
    tick(8);
    mode_set = 3'($urandom);
    chk("phase", phase, m == 3'h0 ? lifephase_pkg::PH_DOWNLOAD : lifephase_pkg::PH_IDLE);
    chk("context", ctx_seen, exp_ctx(m));
    if (m != 3'h0) chk("idle", {cfg_if_driven, pin_role.init_status, pin_role.serial_data,
      pin_role.cfg_status_low, pin_role.cfg_status_high}, 0);
    go = 1'b1;
    tick(6);
    go = 1'b0;
    chk("start", phase, v ? lifephase_pkg::PH_DOWNLOAD : lifephase_pkg::PH_IDLE);
    chk("mode held", mode_captured, m);
    if (!v) return;
    dl_check(m, 2'h2);
    download_done = 1'b1;
    tick(1);
    download_done = 1'b0;
    tick(2);
    chk("run", {phase, design_running, gpio_policy, pin_role},
      {lifephase_pkg::PH_RUN, 1'b1, 2'h1, lifephase_pkg::pin_role_s'(0)});
    bs_opt = 4'($urandom);
    reconfig_req = 1'b1;
    tick(1);
    reconfig_req = 1'b0;
    tick(2);
    dl_check(m, 2'h1);
  endtask
  // ====
  // Main sequence
  logic [2:0] modes [6] = '{3'h0, 3'h1, 3'h7, 3'h2, 3'h6, 3'h3};
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // Hang guard well above the few hundred cycles the sequence needs
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      summarize();
    end
  end
  initial begin
    void'($urandom(83));
    {nrst, go, download_done, reconfig_req, bs_opt, mode_set} = '0;
    tick(12);
    foreach (modes[i]) run_mode(modes[i], 4'($urandom));
    run_mode(3'h2, 4'hf);
    run_mode(3'h6, 4'h0);
    repeat (4) run_mode(modes[$urandom % 5], 4'($urandom));
    summarize();
  end
endmodule
